// >>> src/clio_pkg.sv
// Package: register map, field layouts, reset values and timing constants
`default_nettype none
package clio_pkg;
    localparam int CLIO_LINES = 4;
    localparam int CLIO_SOFT_OUTS = 4;

    // Register byte offsets
    localparam logic [7:0] CLIO_LINE_CHOICE_OFF = 8'h00;
    localparam logic [7:0] CLIO_LINE_CFG_OFF = 8'h04;
    localparam logic [7:0] CLIO_FILTER_CHOICE_OFF = 8'h08;
    localparam logic [7:0] CLIO_FILTER_SPAN_OFF = 8'h0C;
    localparam logic [7:0] CLIO_LINE_STATUS_OFF = 8'h10;
    localparam logic [7:0] CLIO_ALL_LEVELS_OFF = 8'h14;
    localparam logic [7:0] CLIO_SOFT_CHOICE_OFF = 8'h18;
    localparam logic [7:0] CLIO_SOFT_LEVEL_OFF = 8'h1C;
    localparam logic [7:0] CLIO_SOFT_ALL_OFF = 8'h20;

    // Line configuration word fields
    localparam int CLIO_CFG_DIR_BIT = 0;
    localparam int CLIO_CFG_FLIP_BIT = 1;
    localparam int CLIO_CFG_AUX_BIT = 2;
    localparam int CLIO_CFG_SRC_LSB = 4;
    localparam int CLIO_SRC_W = 4;
    // Line status word fields
    localparam int CLIO_STAT_LEVEL_BIT = 0;
    localparam int CLIO_STAT_KIND_LSB = 4;

    localparam int CLIO_SPAN_W = 16;
    localparam logic [CLIO_SPAN_W-1:0] CLIO_SPAN_RESET = 16'h0000;

    // Timebase: one tick per microsecond
    localparam int CLIO_CLK_MHZ = 250;
    localparam int CLIO_TICK_US = 1;
    localparam int CLIO_TICK_CYCLES = CLIO_TICK_US * CLIO_CLK_MHZ;
    localparam int CLIO_TICK_W = 8;

    typedef enum logic [3:0] {
        CLIO_SRC_OFF = 4'h0,
        CLIO_SRC_LINE0 = 4'h1,
        CLIO_SRC_LINE1 = 4'h2,
        CLIO_SRC_LINE2 = 4'h3,
        CLIO_SRC_LINE3 = 4'h4,
        CLIO_SRC_SOFT0 = 4'h5,
        CLIO_SRC_SOFT1 = 4'h6,
        CLIO_SRC_SOFT2 = 4'h7,
        CLIO_SRC_SOFT3 = 4'h8,
        CLIO_SRC_CNT0 = 4'h9,
        CLIO_SRC_CNT1 = 4'hA,
        CLIO_SRC_LOGIC0 = 4'hB,
        CLIO_SRC_LOGIC1 = 4'hC,
        CLIO_SRC_EXPOSE = 4'hD,
        CLIO_SRC_TRIGWAIT = 4'hE,
        CLIO_SRC_PPS = 4'hF
    } clio_src_t;
    // The four-bit source code is full, so serial port 0 is picked by a
    // separate bit of the line configuration word that overrides the code
    localparam int CLIO_CFG_SERIAL_BIT = 8;

    typedef enum logic [1:0] {
        CLIO_KIND_TRISTATE = 2'h0,
        CLIO_KIND_OPTO = 2'h1,
        CLIO_KIND_OPENDRAIN = 2'h2
    } clio_kind_t;

    localparam logic CLIO_DIR_INPUT = 1'b0;
    localparam logic CLIO_DIR_OUTPUT = 1'b1;
endpackage
`default_nettype wire

// >>> src/clio_line_filter.sv
// One line's input path: glitch filter followed by bounce filter
`default_nettype none
module clio_line_filter
    import clio_pkg::*;
#(
    parameter int SPAN_W = CLIO_SPAN_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic raw_in,
    input wire logic [SPAN_W-1:0] glitch_span,
    input wire logic [SPAN_W-1:0] bounce_span,
    output logic filt_out
);
    logic glitch_q;
    logic [SPAN_W-1:0] gcnt_q;
    logic bounce_q;
    logic [SPAN_W-1:0] bcnt_q;

    // Glitch stage: level must hold a full span before acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glitch_q <= 1'b0;
            gcnt_q <= '0;
        end else if (raw_in == glitch_q) begin
            gcnt_q <= '0;
        end else if (glitch_span == '0) begin
            glitch_q <= raw_in;
        end else if (tick) begin
            if (gcnt_q + 1'b1 >= glitch_span) begin
                glitch_q <= raw_in;
                gcnt_q <= '0;
            end else begin
                gcnt_q <= gcnt_q + 1'b1;
            end
        end
    end

    // Bounce stage: first edge passes, later changes locked out for span
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bounce_q <= 1'b0;
            bcnt_q <= '0;
        end else if (bcnt_q != '0) begin
            if (tick) begin
                bcnt_q <= bcnt_q - 1'b1;
            end
        end else if (glitch_q != bounce_q) begin
            bounce_q <= glitch_q;
            bcnt_q <= bounce_span;
        end
    end

    assign filt_out = bounce_q;
endmodule
`default_nettype wire

// >>> src/clio_line_io.sv
// Camera line I/O block: four configurable lines behind an APB slave
//
// Implementation choices: the register offsets and register access over APB.
`default_nettype none
module clio_line_io
    import clio_pkg::*;
#(
    parameter int NLINES = CLIO_LINES,
    parameter int SPAN_W = CLIO_SPAN_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NLINES-1:0] line_in,
    output logic [NLINES-1:0] line_out,
    output logic [NLINES-1:0] line_oe,
    output logic aux_rail_on,
    input wire logic [1:0] counter_active,
    input wire logic [1:0] logic_block_out,
    input wire logic sensor_exposing_flag,
    input wire logic frame_trigger_pending,
    input wire logic pps_signal,
    input wire logic serial_tx
);
    ////////////////////////////////////////////////////////////////////////
    // Fixed per-line capabilities
    // Bit n set: line n has the capability; masks clamp software writes
    localparam logic [3:0] CAN_IN = 4'hD;
    localparam logic [3:0] CAN_OUT = 4'h6;
    localparam logic [3:0] HAS_AUX = 4'h4;

    // Circuit kind is fixed by how each line is wired on the board
    function automatic clio_kind_t kind_of(input logic [1:0] idx);
        clio_kind_t k;
        k = CLIO_KIND_TRISTATE;
        if (idx == 2'h0 || idx == 2'h1) begin
            k = CLIO_KIND_OPTO;
        end else if (idx == 2'h2) begin
            k = CLIO_KIND_OPENDRAIN;
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [1:0] line_choice_q;
    logic input_filter_choice_q;
    logic [1:0] soft_output_choice_q;
    logic [NLINES-1:0] dir_q;
    logic [NLINES-1:0] flip_q;
    logic [NLINES-1:0] aux_q;
    logic [NLINES-1:0] ser_q;
    logic [CLIO_SRC_W-1:0] src_q [NLINES];
    logic [SPAN_W-1:0] gspan_q [NLINES];
    logic [SPAN_W-1:0] bspan_q [NLINES];
    logic [CLIO_SOFT_OUTS-1:0] soft_q;

    logic [NLINES-1:0] sync1_q;
    logic [NLINES-1:0] sync2_q;
    logic [NLINES-1:0] filt;
    logic [NLINES-1:0] level;
    logic [NLINES-1:0] drive_d;
    logic [CLIO_TICK_W-1:0] tick_cnt_q;
    logic tick_q;

    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] rdata_d;

    // Writes land only at the edge that completes the transfer, so no
    // register changes while the master still holds the access
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // One-microsecond timebase
    // Spans are whole ticks and the tick phase is free running, so a
    // filter span is only accurate to one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == CLIO_TICK_W'(CLIO_TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // Pins come from outside the clock domain
    // Two flops before the filters cost two cycles of input latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-line input path and level
    genvar g;
    generate
        for (g = 0; g < NLINES; g++) begin : g_line
            clio_line_filter #(.SPAN_W(SPAN_W)) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick_q),
                .raw_in(sync2_q[g]),
                .glitch_span(gspan_q[g]),
                .bounce_span(bspan_q[g]),
                .filt_out(filt[g])
            );
            // Output lines report their driven level
            assign level[g] = (dir_q[g] == CLIO_DIR_OUTPUT) ?
                line_out[g] : (filt[g] ^ flip_q[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output source selection
    always_comb begin
        for (int i = 0; i < NLINES; i++) begin
            logic s;
            s = 1'b0;
            unique case (clio_src_t'(src_q[i]))
                CLIO_SRC_OFF: s = 1'b0;
                CLIO_SRC_LINE0: s = filt[0] ^ flip_q[0];
                CLIO_SRC_LINE1: s = filt[1] ^ flip_q[1];
                CLIO_SRC_LINE2: s = filt[2] ^ flip_q[2];
                CLIO_SRC_LINE3: s = filt[3] ^ flip_q[3];
                CLIO_SRC_SOFT0: s = soft_q[0];
                CLIO_SRC_SOFT1: s = soft_q[1];
                CLIO_SRC_SOFT2: s = soft_q[2];
                CLIO_SRC_SOFT3: s = soft_q[3];
                CLIO_SRC_CNT0: s = counter_active[0];
                CLIO_SRC_CNT1: s = counter_active[1];
                CLIO_SRC_LOGIC0: s = logic_block_out[0];
                CLIO_SRC_LOGIC1: s = logic_block_out[1];
                CLIO_SRC_EXPOSE: s = sensor_exposing_flag;
                CLIO_SRC_TRIGWAIT: s = frame_trigger_pending;
                CLIO_SRC_PPS: s = pps_signal;
            endcase
            // Serial select wins over the four-bit code
            if (ser_q[i]) begin
                s = serial_tx;
            end
            drive_d[i] = s ^ flip_q[i];
        end
    end

    // Drive is registered so the pins never see source decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_out <= '0;
            line_oe <= '0;
            aux_rail_on <= 1'b0;
        end else begin
            line_out <= drive_d & dir_q;
            line_oe <= dir_q & CAN_OUT;
            aux_rail_on <= |(aux_q & HAS_AUX);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB write side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_choice_q <= 2'h0;
            input_filter_choice_q <= 1'b0;
            soft_output_choice_q <= 2'h0;
            soft_q <= '0;
            // Line1 can only drive, so it leaves reset as an output
            dir_q <= ~CAN_IN;
            flip_q <= '0;
            aux_q <= '0;
            ser_q <= '0;
            for (int i = 0; i < NLINES; i++) begin
                src_q[i] <= CLIO_SRC_OFF;
                gspan_q[i] <= CLIO_SPAN_RESET;
                bspan_q[i] <= CLIO_SPAN_RESET;
            end
        end else if (wr_en) begin
            unique case (paddr)
                CLIO_LINE_CHOICE_OFF:
                    if (pstrb[0]) line_choice_q <= pwdata[1:0];
                CLIO_LINE_CFG_OFF: if (pstrb[0]) begin
                    // Direction clamped to what the line's circuit allows
                    dir_q[line_choice_q] <=
                        (pwdata[CLIO_CFG_DIR_BIT] & CAN_OUT[line_choice_q])
                        | ~CAN_IN[line_choice_q];
                    flip_q[line_choice_q] <= pwdata[CLIO_CFG_FLIP_BIT];
                    aux_q[line_choice_q] <= pwdata[CLIO_CFG_AUX_BIT]
                        & HAS_AUX[line_choice_q];
                    src_q[line_choice_q] <=
                        pwdata[CLIO_CFG_SRC_LSB +: CLIO_SRC_W];
                    if (pstrb[1]) begin
                        ser_q[line_choice_q] <= pwdata[CLIO_CFG_SERIAL_BIT];
                    end
                end
                CLIO_FILTER_CHOICE_OFF:
                    if (pstrb[0]) input_filter_choice_q <= pwdata[0];
                // Both low strobes needed so a half-written span never runs
                CLIO_FILTER_SPAN_OFF: if (&pstrb[1:0]) begin
                    if (input_filter_choice_q) begin
                        bspan_q[line_choice_q] <= pwdata[SPAN_W-1:0];
                    end else begin
                        gspan_q[line_choice_q] <= pwdata[SPAN_W-1:0];
                    end
                end
                CLIO_SOFT_CHOICE_OFF:
                    if (pstrb[0]) soft_output_choice_q <= pwdata[1:0];
                CLIO_SOFT_LEVEL_OFF: if (pstrb[0]) begin
                    soft_q[soft_output_choice_q] <= pwdata[0];
                end
                CLIO_SOFT_ALL_OFF: if (pstrb[0]) begin
                    soft_q <= pwdata[CLIO_SOFT_OUTS-1:0];
                end
                default: ; // Read-only or unmapped: no effect
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read side
    always_comb begin
        rdata_d = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr)
            CLIO_LINE_CHOICE_OFF: rdata_d[1:0] = line_choice_q;
            CLIO_LINE_CFG_OFF: begin
                rdata_d[CLIO_CFG_DIR_BIT] = dir_q[line_choice_q];
                rdata_d[CLIO_CFG_FLIP_BIT] = flip_q[line_choice_q];
                rdata_d[CLIO_CFG_AUX_BIT] = aux_q[line_choice_q];
                rdata_d[CLIO_CFG_SRC_LSB +: CLIO_SRC_W] = src_q[line_choice_q];
                rdata_d[CLIO_CFG_SERIAL_BIT] = ser_q[line_choice_q];
            end
            CLIO_FILTER_CHOICE_OFF: rdata_d[0] = input_filter_choice_q;
            CLIO_FILTER_SPAN_OFF: rdata_d[SPAN_W-1:0] =
                input_filter_choice_q ? bspan_q[line_choice_q]
                                      : gspan_q[line_choice_q];
            CLIO_LINE_STATUS_OFF: begin
                rdata_d[CLIO_STAT_LEVEL_BIT] = level[line_choice_q];
                rdata_d[CLIO_STAT_KIND_LSB +: 2] =
                    kind_of(line_choice_q);
            end
            CLIO_ALL_LEVELS_OFF: rdata_d[NLINES-1:0] = level;
            CLIO_SOFT_CHOICE_OFF: rdata_d[1:0] = soft_output_choice_q;
            CLIO_SOFT_LEVEL_OFF: rdata_d[0] = soft_q[soft_output_choice_q];
            CLIO_SOFT_ALL_OFF: rdata_d[CLIO_SOFT_OUTS-1:0] = soft_q;
            default: hit = 1'b0;
        endcase
    end

    // One wait state: answer registered, so pready rises in the second
    // access cycle; sampled levels are a snapshot only at that edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !hit;
            prdata <= rd_en ? rdata_d : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// >>> tb/clio_line_io_assertions.sv
// Port-level checks for the camera line I/O block
`default_nettype none
module clio_line_io_assertions #(
    parameter int NLINES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NLINES-1:0] line_out,
    input wire logic [NLINES-1:0] line_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic taken = psel && penable && !pready;

    ack_timing_a: assert property (taken |=> pready)
        else $error("ready not one cycle after access");
    ack_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ack_cause_a: assert property (pready |-> $past(taken))
        else $error("ready without an access");
    err_with_ack_a: assert property (pslverr |-> pready)
        else $error("error outside ready cycle");
    rdata_idle_a: assert property (!pready |-> prdata == '0)
        else $error("read data not zero outside ready");
    unmapped_err_a: assert property (taken && paddr > 8'h20 |=> pslverr)
        else $error("unmapped access without error");
    fixed_dir_a: assert property (!line_oe[0] && !line_oe[3])
        else $error("input-only line driven");
    idle_drive_a: assert property ((line_out & ~line_oe) == '0)
        else $error("line level driven while not an output");
    level_word_a: assert property (
        pready && !pwrite && paddr == 8'h14 |-> prdata[31:NLINES] == '0)
        else $error("level word has bits above the lines");
    status_kind_a: assert property (
        pready && !pwrite && paddr == 8'h10 |-> prdata[5:4] != 2'h3)
        else $error("circuit kind code out of range");
endmodule
`default_nettype wire

// >>> tb/clio_ext_circuit.sv
// Model of the external circuits wired to the four connector lines
`default_nettype none
module clio_ext_circuit (
    input wire logic [3:0] ext_level,
    input wire logic [3:0] line_out,
    input wire logic [3:0] line_oe,
    output logic [3:0] line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin follows the block; an undriven pin reads the external level
    always_comb line_in = (line_oe & line_out) | (~line_oe & ext_level);
endmodule
`default_nettype wire

// >>> tb/clio_line_io_tb_top.sv
// Self-checking bench for the camera line I/O block
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module clio_line_io_tb_top;
    import clio_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0] pstrb = '0, line_in, line_out, line_oe, ext_level = '0;
    logic pready, pslverr, aux_rail_on, serr;
    logic [1:0] cnt_act = '0, lb_out = '0;
    logic expo = 0, trig = 0, pps = 0, ser = 0;
    logic [15:0] srcv;
    logic [3:0] caps = 4'b0110;
    clio_kind_t kinds [4] = '{CLIO_KIND_OPTO, CLIO_KIND_OPTO,
        CLIO_KIND_OPENDRAIN, CLIO_KIND_TRISTATE};
    int bad_count = 0, checks = 0, cyc = 0;

    initial forever #2 pclk = ~pclk;

    clio_line_io #(.NLINES(4), .SPAN_W(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
        .aux_rail_on(aux_rail_on), .counter_active(cnt_act),
        .logic_block_out(lb_out), .sensor_exposing_flag(expo),
        .frame_trigger_pending(trig), .pps_signal(pps), .serial_tx(ser));
    clio_ext_circuit ext (.ext_level(ext_level), .line_out(line_out),
        .line_oe(line_oe), .line_in(line_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] a,
            input logic [31:0] e);
        apb(1'b0, a, '0);
        `CHK(n, e, rdat)
    endtask
    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hang in a bus wait ends here
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc("cfg0", 8'h04, 32'h0);
        `CHK("oe1_rst", 1'b1, line_oe[1])
        rdc("span", 8'h0C, 32'h0);
        rdc("soft_all", 8'h20, 32'h0);
        rdc("unmapped", 8'h24, 32'h0);
        `CHK("unmapped_err", 1'b1, serr)
        wr(8'h20, 32'hA);
        rdc("soft_all", 8'h20, 32'hA);
        wr(8'h18, 32'h2);
        wr(8'h1C, 32'h1);
        rdc("soft_all", 8'h20, 32'hE);
        wr(8'h18, 32'h0);
        rdc("soft_lvl", 8'h1C, 32'h0);
        wr(8'h14, 32'hF);
        rdc("levels_ro", 8'h14, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'(i));
            rdc("kind", 8'h10, {26'h0, kinds[i], 4'h0});
            wr(8'h04, 32'h1);
            apb(1'b0, 8'h04, '0);
            `CHK("dir", caps[i], rdat[0])
            wr(8'h04, 32'h0);
        end
        // Every source code except off and line1 itself drives line1, twice with opposite values
        wr(8'h00, 32'h1);
        for (int k = 0; k < 2; k++) begin
            cnt_act <= (k == 1) ? 2'b10 : 2'b01;
            lb_out <= (k == 1) ? 2'b01 : 2'b10;
            expo <= (k == 1);
            trig <= (k == 0);
            pps <= (k == 1);
            ext_level <= (k == 1) ? 4'b1000 : 4'b0101;
            wr(8'h20, (k == 1) ? 32'h9 : 32'h6);
            repeat (8) @(posedge pclk);
            srcv = {pps, trig, expo, lb_out, cnt_act, (k == 1) ? 4'h9 : 4'h6,
                ext_level[3:2], 1'b0, ext_level[0], 1'b0};
            for (int c = 1; c < 16; c++) begin
                if (c != 2) begin
                    wr(8'h04, 32'h1 | (32'(c) << 4));
                    repeat (8) @(posedge pclk);
                    `CHK("src", srcv[c], line_out[1])
                end
            end
        end
        `CHK("oe1", 1'b1, line_oe[1])
        wr(8'h04, 32'h53);
        repeat (8) @(posedge pclk);
        `CHK("flip_out", 1'b0, line_out[1])
        wr(8'h04, 32'h101);
        ser <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("serial", 1'b1, line_out[1])
        ser <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("serial", 1'b0, line_out[1])
        // Line2 driven, then turned back to input with the source kept
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h51);
        repeat (8) @(posedge pclk);
        `CHK("drive2", 2'b11, {line_oe[2], line_out[2]})
        wr(8'h04, 32'h54);
        repeat (8) @(posedge pclk);
        `CHK("drive2", 2'b00, {line_oe[2], line_out[2]})
        `CHK("aux_on", 1'b1, aux_rail_on)
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h4);
        repeat (8) @(posedge pclk);
        `CHK("aux_off", 1'b0, aux_rail_on)
        rdc("cfg3", 8'h04, 32'h0);
        ext_level <= 4'b1101;
        // Status is sampled at read time, so let the pins settle first
        repeat (8) @(posedge pclk);
        rdc("lvl3", 8'h10, 32'h1);
        wr(8'h04, 32'h2);
        rdc("lvl3_flip", 8'h10, 32'h0);
        rdc("levels", 8'h14, 32'h5);
        wr(8'h04, 32'h0);
        ext_level <= 4'b0000;
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h4);
        rdc("span_g", 8'h0C, 32'h4);
        wr(8'h08, 32'h1);
        rdc("span_b", 8'h0C, 32'h0);
        ext_level <= 4'b1000;
        repeat (250) @(posedge pclk);
        ext_level <= 4'b0000;
        repeat (1500) @(posedge pclk);
        rdc("glitch_rej", 8'h10, 32'h0);
        ext_level <= 4'b1000;
        repeat (500) @(posedge pclk);
        rdc("glitch_dly", 8'h10, 32'h0);
        repeat (1500) @(posedge pclk);
        rdc("glitch_acc", 8'h10, 32'h1);
        // Bounce on line0, then a short pulse with both filters on
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h4);
        ext_level <= 4'b1001;
        repeat (10) @(posedge pclk);
        rdc("bounce_edge", 8'h10, 32'h11);
        ext_level <= 4'b1000;
        repeat (10) @(posedge pclk);
        rdc("bounce_hold", 8'h10, 32'h11);
        repeat (1500) @(posedge pclk);
        rdc("bounce_end", 8'h10, 32'h10);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h4);
        // Let the bounce lockout of the last edge run out first
        repeat (1000) @(posedge pclk);
        ext_level <= 4'b1001;
        repeat (250) @(posedge pclk);
        ext_level <= 4'b1000;
        // An unlocked bounce stage would pass the pulse if it came first
        repeat (10) @(posedge pclk);
        rdc("chain", 8'h10, 32'h10);
        ext_level <= 4'b1001;
        repeat (1500) @(posedge pclk);
        rdc("chain_acc", 8'h10, 32'h11);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("soft_rst", 8'h20, 32'h0);
        summarize();
    end
endmodule

bind clio_line_io clio_line_io_assertions #(.NLINES(NLINES)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_out(line_out), .line_oe(line_oe));
`default_nettype wire
